// ===== sldr_buf2.sv
// Purpose: Two-entry buffer with valid and ready on both sides
// Assumes: Single clock, synchronous active-high reset
// Notes: Read data comes straight from the entry flip-flops
`timescale 1ns/1ps
`default_nettype none
`include "sldr_defs.svh"
module sldr_buf2 #(
    parameter int WIDTH = `SLDR_BUF_WIDTH
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Fill side
    input wire logic i_in_valid,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_in_ready,
    // Drain side
    output logic o_out_valid,
    output logic [WIDTH-1:0] o_out_data,
    input wire logic i_out_ready
);
    import sldr_pkg::*;

    initial begin
        if (WIDTH < 1) begin
            $error("sldr_buf2: WIDTH must be at least 1");
        end
    end

    logic [WIDTH-1:0] mem_reg [2];
    logic [WIDTH-1:0] mem_next [2];
    logic wr_ptr_reg, wr_ptr_next;
    logic rd_ptr_reg, rd_ptr_next;
    logic [1:0] count_reg, count_next;
    logic push, pop;

    assign o_in_ready = (count_reg != 2'h2);
    assign o_out_valid = (count_reg != 2'h0);
    assign o_out_data = mem_reg[rd_ptr_reg];
    assign push = i_in_valid & o_in_ready;
    assign pop = o_out_valid & i_out_ready;

    always_comb begin
        mem_next = mem_reg;
        wr_ptr_next = wr_ptr_reg;
        rd_ptr_next = rd_ptr_reg;
        count_next = count_reg;
        if (push) begin
            mem_next[wr_ptr_reg] = i_in_data;
            wr_ptr_next = ~wr_ptr_reg;
        end
        if (pop) begin
            rd_ptr_next = ~rd_ptr_reg;
        end
        if (push && !pop) begin
            count_next = count_reg + 2'h1;
        end else if (pop && !push) begin
            count_next = count_reg - 2'h1;
        end
    end

    always_ff @(posedge i_clk) begin
        mem_reg <= mem_next;
        if (i_rst) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg <= 2'h0;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg <= count_next;
        end
    end
endmodule
`default_nettype wire

// ===== sldr_defs.svh
// Purpose: Constants for the serial-in latched driver logic
// Assumes: Included by bare name
// Notes: Counts and reset values; the types live in sldr_pkg
`ifndef SLDR_DEFS_SVH
`define SLDR_DEFS_SVH

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define SLDR_STAGES 20
`define SLDR_BUF_DEPTH 2
`define SLDR_BUF_WIDTH 1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SLDR_SHIFT_RST 1'b0
`define SLDR_LATCH_RST 1'b0

`endif

// ===== sldr_host.sv
// Purpose: Host model driving serial data, shift clock and latch-load
// Assumes: Called from the bench, acts at falling reference-clock edges
// Notes: Widths counted in 40 ns cycles; waits on cascade room
`timescale 1ns/1ps
`default_nettype none
module sldr_host (
    // Clock and flow control
    input wire logic i_clk,
    input wire logic i_ready,
    // Serial side
    output logic o_data,
    output logic o_sclk,
    output logic o_load
);
    initial begin
        o_data = 1'b0;
        o_sclk = 1'b0;
        o_load = 1'b0;
    end
    task automatic wait_n(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    // 4 high plus 6 low cycles: 400 ns, 2.5 MHz
    task automatic put_bit(input logic b);
        int w;
        w = 0;
        o_data = b;
        wait_n(2);
        while (i_ready !== 1'b1 && w < 400) begin
            wait_n(1);
            w++;
        end
        o_sclk = 1'b1;
        wait_n(4);
        o_sclk = 1'b0;
        wait_n(2);
        // Hold over: line no longer shows the old bit
        o_data = ~b;
        wait_n(2);
    endtask
    task automatic strobe();
        wait_n(8);
        o_load = 1'b1;
        wait_n(3);
        o_load = 1'b0;
    endtask
    task automatic set_load(input logic v);
        o_load = v;
    endtask
endmodule
`default_nettype wire

// ===== sldr_pkg.sv
// Purpose: Types for the serial-in latched driver logic
// Assumes: Nothing
// Notes: One-hot codes written out
package sldr_pkg;
    typedef enum logic [1:0] {
        SLDR_DRV_BLANK = 2'b01,
        SLDR_DRV_LATCH = 2'b10
    } sldr_drv_type;
endpackage

// ===== sldr_top.sv
// Purpose: Serial-in shift register, output latches and blanking
// Assumes: All inputs synchronous to I_REF_CLK (25 MHz)
// Notes: Shift clock edges are found by sampling at the system clock
// Notes on behaviour
// - There are N (20) shift stages, each with its own latch and driver.
// - A rising shift-clock edge with shift-ready high loads the serial input into stage one.
// - A rising shift-clock edge with shift-ready high moves every stage one step onward.
// - The cascade output shows the last shift stage.
// - While latch-load is high each latch takes its shift stage.
// - Latches follow while latch-load is high and hold while it is low.
// - While blanking is high all sources are off and all pull-downs on.
// - Blanking leaves the latch contents untouched.
// - While blanking is low each output follows its latch.
`timescale 1ns/1ps
`default_nettype none
`include "sldr_defs.svh"
module sldr_top #(
    parameter int NUM_STAGES = `SLDR_STAGES
) (
    // Clock and reset
    input wire logic I_REF_CLK,
    input wire logic I_RST,
    // Host serial side
    input wire logic I_SER_DATA,
    input wire logic I_SHIFT_CLK,
    input wire logic I_LOAD,
    input wire logic I_BLANK,
    output logic O_SHIFT_READY,
    // Cascade
    output logic O_SER_OUT,
    output logic O_CAS_VALID,
    output logic O_CAS_BIT,
    input wire logic I_CAS_READY,
    // Drivers
    output logic [NUM_STAGES-1:0] O_DRV_LEVEL,
    output logic [NUM_STAGES-1:0] O_SRC_EN,
    output logic [NUM_STAGES-1:0] O_SINK_EN,
    output sldr_pkg::sldr_drv_type O_DRV_MODE
);
    import sldr_pkg::*;

    initial begin
        if (NUM_STAGES < 2) begin
            $error("sldr_top: NUM_STAGES must be at least 2");
        end
    end

    // ----------------------------------------------------------------
    // Shift clock edge detection
    // ----------------------------------------------------------------
    logic sclk_prev_reg, sclk_prev_next;
    logic sclk_rise;
    logic shift_take;
    logic buf_in_ready;

    always_comb begin
        sclk_prev_next = I_SHIFT_CLK;
    end

    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            sclk_prev_reg <= 1'b0;
        end else begin
            sclk_prev_reg <= sclk_prev_next;
        end
    end

    // Only low-to-high counts; falling edges do nothing
    assign sclk_rise = I_SHIFT_CLK & ~sclk_prev_reg;
    // A rise with the cascade buffer full is refused, not half done
    assign shift_take = sclk_rise & buf_in_ready;
    assign O_SHIFT_READY = buf_in_ready;

    // ----------------------------------------------------------------
    // Shift register
    // ----------------------------------------------------------------
    logic [NUM_STAGES-1:0] shift_reg, shift_next;

    always_comb begin
        shift_next = shift_reg;
        if (shift_take) begin
            // Stage 0 takes the input, the rest move on
            shift_next = {shift_reg[NUM_STAGES-2:0], I_SER_DATA};
        end
    end

    // Reset gives a known pattern that the host must still overwrite
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            shift_reg <= {NUM_STAGES{`SLDR_SHIFT_RST}};
        end else begin
            shift_reg <= shift_next;
        end
    end

    assign O_SER_OUT = shift_reg[NUM_STAGES-1];

    // ----------------------------------------------------------------
    // Cascade stream buffer
    // ----------------------------------------------------------------
    // Each bit pushed out of the last stage is also queued, so a
    // downstream receiver that stalls loses nothing.
    sldr_buf2 #(
        .WIDTH(1)
    ) u_cas_buf (
        .i_clk(I_REF_CLK),
        .i_rst(I_RST),
        .i_in_valid(sclk_rise),
        .i_in_data(shift_reg[NUM_STAGES-1]),
        .o_in_ready(buf_in_ready),
        .o_out_valid(O_CAS_VALID),
        .o_out_data(O_CAS_BIT),
        .i_out_ready(I_CAS_READY)
    );

    // ----------------------------------------------------------------
    // Output latches
    // ----------------------------------------------------------------
    logic [NUM_STAGES-1:0] latch_reg, latch_next;

    // Transparent latch modelled one clock behind the stage it follows
    always_comb begin
        latch_next = latch_reg;
        if (I_LOAD) begin
            latch_next = shift_reg;
        end
    end

    // Blanking never reaches this register
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            latch_reg <= {NUM_STAGES{`SLDR_LATCH_RST}};
        end else begin
            latch_reg <= latch_next;
        end
    end

    // ----------------------------------------------------------------
    // Output drivers
    // ----------------------------------------------------------------
    sldr_drv_type mode_reg, mode_next;
    logic [NUM_STAGES-1:0] level_reg, level_next;
    logic [NUM_STAGES-1:0] src_reg, src_next;
    logic [NUM_STAGES-1:0] sink_reg, sink_next;

    always_comb begin
        mode_next = I_BLANK ? SLDR_DRV_BLANK : SLDR_DRV_LATCH;
        level_next = '0;
        src_next = '0;
        sink_next = '1;
        unique case (mode_next)
            SLDR_DRV_BLANK: begin
                level_next = '0;
                src_next = '0;
                sink_next = '1;
            end
            SLDR_DRV_LATCH: begin
                level_next = latch_reg;
                src_next = latch_reg;
                sink_next = ~latch_reg;
            end
        endcase
    end

    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            mode_reg <= SLDR_DRV_BLANK;
            level_reg <= '0;
            src_reg <= '0;
            sink_reg <= '1;
        end else begin
            mode_reg <= mode_next;
            level_reg <= level_next;
            src_reg <= src_next;
            sink_reg <= sink_next;
        end
    end

    assign O_DRV_MODE = mode_reg;
    assign O_DRV_LEVEL = level_reg;
    assign O_SRC_EN = src_reg;
    assign O_SINK_EN = sink_reg;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge I_REF_CLK);
    endclocking
    default disable iff (I_RST);

    sequence s_shift_taken;
        shift_take;
    endsequence

    sequence s_no_rise;
        !sclk_rise;
    endsequence

    a_first_stage_load: assert property (
        s_shift_taken |=> shift_reg[0] == $past(I_SER_DATA))
        else $error("stage one missed the serial input");

    a_stages_move_on: assert property (
        s_shift_taken |=> shift_reg[NUM_STAGES-1:1]
            == $past(shift_reg[NUM_STAGES-2:0]))
        else $error("stages did not move one step");

    a_fall_holds_stages: assert property (
        s_no_rise |=> $stable(shift_reg) && $stable(O_SER_OUT))
        else $error("stages changed without a rising edge");

    a_cascade_last: assert property (
        s_shift_taken ##1 1'b1 |-> O_SER_OUT == $past(shift_reg[NUM_STAGES-2]))
        else $error("cascade output not the last stage");

    a_latch_follows: assert property (
        I_LOAD [*2] |=> latch_reg == $past(shift_reg))
        else $error("latch did not follow its stage");

    a_latch_holds: assert property (
        !I_LOAD |=> $stable(latch_reg))
        else $error("latch changed with load low");

    a_blank_all_off: assert property (
        I_BLANK |=> O_SRC_EN == '0 && O_SINK_EN == '1 && O_DRV_LEVEL == '0)
        else $error("outputs not blanked");

    a_blank_keeps_latch: assert property (
        $rose(I_BLANK) && !I_LOAD |=> latch_reg == $past(latch_reg))
        else $error("blanking disturbed the latches");

    a_output_follows: assert property (
        !I_BLANK ##1 !I_BLANK |-> ##1 O_DRV_LEVEL == $past(latch_reg)
            && O_SINK_EN == ~$past(latch_reg))
        else $error("output not following its latch");
endmodule
`default_nettype wire

// ===== testbench.sv
// Purpose: Self-checking bench for the latched driver logic
// Assumes: Host model in sldr_host, inputs changed at falling edges
// Notes: Cascade bits are collected and compared at the end of t_bypass
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import sldr_pkg::*;
    localparam int N = 20;
    logic clk, rst, blank, cas_rdy, ser, sclk, load;
    logic shift_rdy, ser_out, cas_vld, cas_bit;
    logic [N-1:0] lvl, src, sink, mdl;
    sldr_drv_type mode;
    logic exp_q[$];
    logic got_q[$];
    int fail_count, checked, cycles;
    sldr_top #(
        .NUM_STAGES(N)
    ) dut (
        .I_REF_CLK(clk),
        .I_RST(rst),
        .I_SER_DATA(ser),
        .I_SHIFT_CLK(sclk),
        .I_LOAD(load),
        .I_BLANK(blank),
        .O_SHIFT_READY(shift_rdy),
        .O_SER_OUT(ser_out),
        .O_CAS_VALID(cas_vld),
        .O_CAS_BIT(cas_bit),
        .I_CAS_READY(cas_rdy),
        .O_DRV_LEVEL(lvl),
        .O_SRC_EN(src),
        .O_SINK_EN(sink),
        .O_DRV_MODE(mode)
    );
    sldr_host host (
        .i_clk(clk),
        .i_ready(shift_rdy),
        .o_data(ser),
        .o_sclk(sclk),
        .o_load(load)
    );
    initial clk = 1'b0;
    always #20 clk = ~clk;
    task automatic conclude();
        if (fail_count == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Timeout well above the roughly 730 cycles used
    always @(posedge clk) begin
        cycles++;
        if (rst === 1'b0 && cas_vld === 1'b1 && cas_rdy === 1'b1) begin
            got_q.push_back(cas_bit);
        end
        if (cycles == 5000) begin
            fail_count++;
            conclude();
        end
    end
    task automatic chk(input string nm, input logic [N-1:0] seen,
            input logic [N-1:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic send(input logic [N-1:0] w, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            exp_q.push_back(mdl[N-1]);
            mdl = {mdl[N-2:0], w[i]};
            host.put_bit(w[i]);
        end
    endtask
    task automatic drv(input logic [N-1:0] l, input logic [N-1:0] s,
            input logic [N-1:0] k, input sldr_drv_type m);
        chk("level", lvl, l);
        chk("source", src, s);
        chk("sink", sink, k);
        chk("mode", N'(mode), N'(m));
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        drv('0, '0, '1, SLDR_DRV_BLANK);
        chk("cas valid", N'(cas_vld), '0);
        chk("ready", N'(shift_rdy), N'(1));
    endtask
    task automatic t_hold();
        blank = 1'b0;
        send(20'ha5c3e, N);
        drv('0, '0, '1, SLDR_DRV_LATCH);
        chk("ser out", N'(ser_out), N'(1));
        host.strobe();
        host.wait_n(3);
        drv(20'ha5c3e, 20'ha5c3e, 20'h5a3c1, SLDR_DRV_LATCH);
    endtask
    task automatic t_blank();
        blank = 1'b1;
        host.wait_n(2);
        drv('0, '0, '1, SLDR_DRV_BLANK);
        blank = 1'b0;
        host.wait_n(2);
        chk("level kept", lvl, 20'ha5c3e);
    endtask
    // One bit: a second shift on the fall would break both checks
    task automatic t_fall();
        send(20'h00001, 1);
        chk("ser out", N'(ser_out), N'(mdl[N-1]));
        host.strobe();
        host.wait_n(3);
        chk("shifted", lvl, mdl);
    endtask
    task automatic t_stall();
        cas_rdy = 1'b0;
        fork
            send(20'h3c96f, N);
            begin
                repeat (60) @(negedge clk);
                chk("ready full", N'(shift_rdy), '0);
                chk("cas held", N'(cas_vld), N'(1));
                cas_rdy = 1'b1;
            end
        join
    endtask
    // Latches bypassed: blanking covers the shifting
    task automatic t_bypass();
        blank = 1'b1;
        host.set_load(1'b1);
        send(20'h81e47, N);
        chk("blanked", lvl, '0);
        blank = 1'b0;
        host.wait_n(3);
        chk("follow", lvl, 20'h81e47);
        host.set_load(1'b0);
        host.wait_n(4);
        chk("cas count", N'(got_q.size()), N'(exp_q.size()));
        foreach (exp_q[i]) begin
            chk("cas bit", N'(got_q[i]), N'(exp_q[i]));
        end
    endtask
    // Reset in mid-run must clear stages and latches, then shift anew
    task automatic t_rerun();
        rst = 1'b1;
        host.wait_n(2);
        drv('0, '0, '1, SLDR_DRV_BLANK);
        chk("ser out rst", N'(ser_out), '0);
        chk("cas valid rst", N'(cas_vld), '0);
        rst = 1'b0;
        mdl = '0;
        host.wait_n(2);
        chk("latch cleared", lvl, '0);
        chk("ready rst", N'(shift_rdy), N'(1));
        send(20'h00003, 2);
        chk("ser out rerun", N'(ser_out), '0);
        host.set_load(1'b1);
        host.wait_n(3);
        host.set_load(1'b0);
        chk("rerun level", lvl, 20'h00003);
    endtask
    initial begin
        rst = 1'b1;
        blank = 1'b1;
        cas_rdy = 1'b1;
        mdl = '0;
        fail_count = 0;
        checked = 0;
        cycles = 0;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        t_reset();
        t_hold();
        t_blank();
        t_fall();
        t_stall();
        t_bypass();
        t_rerun();
        conclude();
    end
endmodule
`default_nettype wire
